// [pkg/arcs_pkg.sv]
// constants, codes and helpers for the audio routing and clock select block
// assumes one core clock at 50 MHz and a register port decoded upstream

package arcs_pkg;

   // register port geometry
   localparam int REG_AW = 7;
   localparam int REG_DW = 9;
   localparam int REG_NUM = 7;

   // register indices into the file
   localparam int IDX_CLK = 0;
   localparam int IDX_PCFG3 = 1;
   localparam int IDX_PCFG4 = 2;
   localparam int IDX_SCFG2 = 3;
   localparam int IDX_DACC1 = 4;
   localparam int IDX_ADCC1 = 5;
   localparam int IDX_SPTX0 = 6;

   // register addresses, in index order
   localparam logic [REG_AW-1:0] REG_ADDR [REG_NUM] = '{
      7'h08, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h1D, 7'h1E};

   // reset values, in index order
   localparam logic [REG_DW-1:0] REG_RESET [REG_NUM] = '{
      9'h010, 9'h1A4, 9'h080, 9'h000, 9'h000, 9'h040, 9'h000};

   // field positions
   localparam int SRC_LSB = 7;
   localparam int CLKSEL_LSB = 0;
   localparam int RX2DAC_BIT = 8;
   localparam int HPD_BIT = 4;
   localparam int OSR_BIT = 3;
   localparam int MUTEL_BIT = 0;
   localparam int MUTER_BIT = 1;
   localparam int MUTEALL_BIT = 2;
   localparam int SPDIF_TX_SOURCE_SEL_LSB = 0;
   localparam int THROUGH_BIT = 3;
   localparam int PINSEL_LSB = 0;
   localparam int PINSEL_STEP = 2;

   // data source codes shared by all source fields
   localparam logic [1:0] SRC_SPDIF = 2'h0;
   localparam logic [1:0] SRC_ADC = 2'h1;
   localparam logic [1:0] SRC_SECONDARY = 2'h2;
   localparam logic [1:0] SRC_PRIMARY = 2'h3;

   // dac clock source codes
   localparam logic [1:0] CLK_MCLK = 2'h0;
   localparam logic [1:0] CLK_PLLA = 2'h1;
   localparam logic [1:0] CLK_PLLB = 2'h2;

   // ratio codes, 128fs up to 1152fs
   localparam logic [2:0] RATIO_128 = 3'h0;
   localparam logic [2:0] RATIO_192 = 3'h1;
   localparam int RATIO_NUM = 7;
   localparam longint RATIO_FS [RATIO_NUM] = '{
      128, 192, 256, 384, 512, 768, 1152};

   // core clock and frame period counter
   localparam longint CORE_CLK_HZ = 50_000_000;
   localparam int PERIOD_W = 16;
   localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hFFFF;
   localparam logic [PERIOD_W-1:0] PERIOD_ONE = 16'h0001;

   // adc oversampling rate, one-hot
   typedef enum logic [2:0] {
      ARCS_OSR_128 = 3'b001,
      ARCS_OSR_64 = 3'b010,
      ARCS_OSR_32 = 3'b100
   } arcs_osr_t;

   // dac rate reference frame clock, one-hot
   typedef enum logic [2:0] {
      ARCS_REF_PRIMARY = 3'b001,
      ARCS_REF_SECONDARY = 3'b010,
      ARCS_REF_SUBFRAME = 3'b100
   } arcs_ref_t;

   // frame period in core cycles halfway between ratio i and i+1
   function automatic logic [PERIOD_W-1:0] arcs_threshold(
      input longint mclk_hz, input int i);
      longint t;
      t = ((RATIO_FS[i] + RATIO_FS[i+1]) * CORE_CLK_HZ) / (2 * mclk_hz);
      if (t > longint'(PERIOD_MAX))
      begin
         t = longint'(PERIOD_MAX);
      end
      return t[PERIOD_W-1:0];
   endfunction : arcs_threshold

endpackage : arcs_pkg

// [hdl/arcs_rate_meter.sv]
// measures the reference frame period and picks the dac clock ratio
// assumes the frame clock input is already synchronised to core_clk_i
`timescale 1ns/100ps

module arcs_rate_meter #(
   parameter longint MCLK_PIN_HZ = 12_288_000,
   parameter longint PLL_A_HZ = 12_288_000,
   parameter longint PLL_B_HZ = 11_289_600
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic frame_clk_i,
   input wire logic [1:0] clk_source_i,
   output logic [2:0] rate_code_o
);
   import arcs_pkg::*;

   logic frame_q;
   logic [PERIOD_W-1:0] count_q, count_d;
   logic [PERIOD_W-1:0] period_q;
   logic [RATIO_NUM-2:0] above;
   logic [2:0] rate_code_d;
   wire frame_rise = frame_clk_i & ~frame_q;

   // saturating count keeps a stopped frame clock from wrapping
   assign count_d = (count_q == PERIOD_MAX) ? count_q : count_q + PERIOD_ONE;

   // period between frame clock rising edges
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         frame_q <= 1'b0;
         count_q <= '0;
         period_q <= '0;
      end
      else
      begin
         frame_q <= frame_clk_i;
         count_q <= frame_rise ? PERIOD_ONE : count_d;
         if (frame_rise)
            period_q <= count_q;
      end
   end

   // one comparator per boundary between neighbouring ratios
   generate
      for (genvar i = 0; i < RATIO_NUM - 1; i++)
      begin : g_bound
         localparam logic [PERIOD_W-1:0] THR_M =
            arcs_threshold(MCLK_PIN_HZ, i);
         localparam logic [PERIOD_W-1:0] THR_A = arcs_threshold(PLL_A_HZ, i);
         localparam logic [PERIOD_W-1:0] THR_B = arcs_threshold(PLL_B_HZ, i);
         wire [PERIOD_W-1:0] thr =
            (clk_source_i == CLK_PLLA) ? THR_A :
            (clk_source_i == CLK_PLLB) ? THR_B : THR_M;
         assign above[i] = period_q > thr;
      end
   endgenerate

   // count of boundaries passed is the ratio code
   always_comb
   begin
      rate_code_d = RATIO_128;
      for (int i = 0; i < RATIO_NUM - 1; i++)
         rate_code_d = rate_code_d + {2'h0, above[i]};
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rate_code_o <= RATIO_128;
      else
         rate_code_o <= rate_code_d;
   end

endmodule : arcs_rate_meter

// [hdl/arcs_routing.sv]
// register file, data routing, adc controls and dac clock selection
// assumes the register port is decoded upstream on core_clk_i, pins are
// asynchronous, and the converters and transmitters sit on core_clk_i
`timescale 1ns/100ps

module arcs_routing #(
   parameter longint MCLK_PIN_HZ = 12_288_000,
   parameter longint PLL_A_HZ = 12_288_000,
   parameter longint PLL_B_HZ = 11_289_600
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [arcs_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic [arcs_pkg::REG_DW-1:0] reg_wdata_i,
   output logic [arcs_pkg::REG_DW-1:0] reg_rdata_o,
   // serial data pins and internal streams
   input wire logic [2:0] dac_serial_inputs_i,
   input wire logic spdif_rx_data_i,
   input wire logic secondary_rx_data_i,
   input wire logic adc_data_i,
   input wire logic spdif_tx_stream_i,
   input wire logic spdif_in_mux_i,
   // frame clocks and adc clock ratio
   input wire logic primary_rx_frame_clock_i,
   input wire logic secondary_frame_clock_i,
   input wire logic spdif_subframe_clock_i,
   input wire logic [2:0] adc_clock_ratio_i,
   // routed data
   output logic [2:0] dac_data_o,
   output logic primary_tx_data_o,
   output logic secondary_tx_data_o,
   output logic spdif_tx_data_o,
   output logic spdif_out_pin_o,
   // adc controls
   output logic adc_highpass_bypass_o,
   output arcs_pkg::arcs_osr_t adc_osr_o,
   output logic adc_left_mute_o,
   output logic adc_right_mute_o,
   // dac clocking
   output logic [1:0] dac_clk_source_o,
   output logic dac23_power_down_o,
   output arcs_pkg::arcs_ref_t dac_rate_ref_o,
   output logic [2:0] dac_rate_code_o
);
   import arcs_pkg::*;

   // pins and foreign frame clocks that pass the two-flop chain
   localparam int SYNC_W = 7;
   // pin select code that carries silence instead of a pin
   localparam logic [1:0] PIN_SILENT = 2'h3;

   // storage, read path and synchroniser chains
   logic [REG_DW-1:0] regs_q [REG_NUM];
   logic [REG_NUM-1:0] hit;
   logic [REG_DW-1:0] rdata_d;
   logic [SYNC_W-1:0] sync1_q, sync2_q;

   // register file, one process per register
   // writes to unmapped addresses match no entry and change nothing

   generate
      for (genvar i = 0; i < REG_NUM; i++)
      begin : g_reg
         assign hit[i] = reg_addr_i == REG_ADDR[i];
         always_ff @(posedge core_clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
               regs_q[i] <= REG_RESET[i];
            else if (reg_wr_i && hit[i])
               regs_q[i] <= reg_wdata_i;
         end
      end
   endgenerate

   // read mux; unmapped addresses read as zero
   always_comb
   begin
      rdata_d = '0;
      for (int i = 0; i < REG_NUM; i++)
         if (hit[i])
            rdata_d = regs_q[i];
   end

   // read data holds until the next read
   // a read and a write of one address in one cycle give the old value
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= '0;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_d;
   end

   // field decode
   // bits 5:0 of the dac1 source register hold the three pin selects
   wire [1:0] dac1_source_sel = regs_q[IDX_PCFG3][SRC_LSB +: 2];
   wire [1:0] primary_tx_source_sel = regs_q[IDX_PCFG4][SRC_LSB +: 2];
   wire [1:0] secondary_tx_source_sel = regs_q[IDX_SCFG2][SRC_LSB +: 2];
   wire [1:0] spdif_tx_source_sel = regs_q[IDX_SPTX0][SPDIF_TX_SOURCE_SEL_LSB +: 2];
   wire spdif_through = regs_q[IDX_SPTX0][THROUGH_BIT];
   wire [1:0] dac_clksel_field = regs_q[IDX_CLK][CLKSEL_LSB +: 2];
   wire receiver_to_dac_mode = regs_q[IDX_DACC1][RX2DAC_BIT];
   wire [REG_DW-1:0] adc_ctl = regs_q[IDX_ADCC1];

   // pins and foreign clocks pass two flops before any logic

   wire [SYNC_W-1:0] sync_in = {spdif_in_mux_i, spdif_subframe_clock_i,
      secondary_frame_clock_i, primary_rx_frame_clock_i,
      dac_serial_inputs_i};

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= sync_in;
         sync2_q <= sync1_q;
      end
   end

   wire [2:0] pin_s = sync2_q[2:0];
   wire prim_frame_s = sync2_q[3];
   wire sec_frame_s = sync2_q[4];
   wire subframe_s = sync2_q[5];
   wire spdif_in_s = sync2_q[6];

   // primary receiver steering: each dac picks one of three pins;
   // the spare select code carries silence
   logic [2:0] prim_data;
   generate
      for (genvar d = 0; d < 3; d++)
      begin : g_steer
         wire [1:0] pin_sel =
            regs_q[IDX_PCFG3][PINSEL_LSB + PINSEL_STEP * d +: 2];
         assign prim_data[d] = (pin_sel == PIN_SILENT) ? 1'b0 :
            pin_s[pin_sel];
      end
   endgenerate

   // dac1 routing; adc code is undefined there and carries zero
   wire dac1_d = (dac1_source_sel == SRC_SPDIF) ? spdif_rx_data_i :
      (dac1_source_sel == SRC_SECONDARY) ? secondary_rx_data_i :
      (dac1_source_sel == SRC_PRIMARY) ? prim_data[0] : 1'b0;

   // receiver mode matters only while dac1 takes spdif data
   wire spdif_to_dac1 = dac1_source_sel == SRC_SPDIF;
   wire power_down_d = spdif_to_dac1 && !receiver_to_dac_mode;

   // dacs 2 and 3 see only primary data, silent while powered down
   // forced silence keeps a powered-down dac from holding stale data
   wire dac2_d = power_down_d ? 1'b0 : prim_data[1];
   wire dac3_d = power_down_d ? 1'b0 : prim_data[2];

   // transmitter sources; the dac1 pin is the primary receiver stream
   // undefined codes give silence rather than a stale stream
   wire ptx_d = (primary_tx_source_sel == SRC_SPDIF) ? spdif_rx_data_i :
      (primary_tx_source_sel == SRC_ADC) ? adc_data_i :
      (primary_tx_source_sel == SRC_SECONDARY) ? secondary_rx_data_i :
      1'b0;
   wire stx_d = (secondary_tx_source_sel == SRC_SPDIF) ? spdif_rx_data_i :
      (secondary_tx_source_sel == SRC_ADC) ? adc_data_i :
      (secondary_tx_source_sel == SRC_PRIMARY) ? prim_data[0] :
      1'b0;
   wire sptx_d = (spdif_tx_source_sel == SRC_SPDIF) ? spdif_rx_data_i :
      (spdif_tx_source_sel == SRC_ADC) ? adc_data_i :
      (spdif_tx_source_sel == SRC_SECONDARY) ? secondary_rx_data_i :
      prim_data[0];

   // through mode bypasses the transmitter for the output pin
   // the synchronised input lags the transmitter path by two cycles
   wire spdif_pin_d = spdif_through ? spdif_in_s :
      spdif_tx_stream_i;

   // dac streams leave through one register stage, bit 0 is dac1
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         dac_data_o <= '0;
      else
         dac_data_o <= {dac3_d, dac2_d, dac1_d};
   end

   // primary transmitter stream
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         primary_tx_data_o <= 1'b0;
      else
         primary_tx_data_o <= ptx_d;
   end

   // secondary transmitter stream
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         secondary_tx_data_o <= 1'b0;
      else
         secondary_tx_data_o <= stx_d;
   end

   // spdif transmitter stream
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         spdif_tx_data_o <= 1'b0;
      else
         spdif_tx_data_o <= sptx_d;
   end

   // spdif output pin
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         spdif_out_pin_o <= 1'b0;
      else
         spdif_out_pin_o <= spdif_pin_d;
   end

   // adc controls

   // low master clock ratios already run at the lower base rate
   wire adc_low_ratio = (adc_clock_ratio_i == RATIO_128) ||
      (adc_clock_ratio_i == RATIO_192);
   // the halve bit is not forced at high rates; software must set it
   wire adc_halve = adc_ctl[OSR_BIT];
   arcs_osr_t osr_d;
   assign osr_d = adc_low_ratio ? (adc_halve ? ARCS_OSR_32 : ARCS_OSR_64) :
      (adc_halve ? ARCS_OSR_64 : ARCS_OSR_128);

   // the both-channels bit overrides the per-channel bits
   wire left_mute_d = adc_ctl[MUTEL_BIT] | adc_ctl[MUTEALL_BIT];
   wire right_mute_d = adc_ctl[MUTER_BIT] | adc_ctl[MUTEALL_BIT];

   // high-pass filter bypass level
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         adc_highpass_bypass_o <= 1'b0;
      else
         adc_highpass_bypass_o <= adc_ctl[HPD_BIT];
   end

   // oversampling rate, one-hot
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         adc_osr_o <= ARCS_OSR_128;
      else
         adc_osr_o <= osr_d;
   end

   // left channel mute
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         adc_left_mute_o <= 1'b0;
      else
         adc_left_mute_o <= left_mute_d;
   end

   // right channel mute
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         adc_right_mute_o <= 1'b0;
      else
         adc_right_mute_o <= right_mute_d;
   end

   // dac clock selection

   // spdif to dac1 forces pll a; code 3 is a second mclk code
   // only a code is produced; glitch-free switching sits downstream
   wire [1:0] clk_src_d = spdif_to_dac1 ? CLK_PLLA :
      (dac_clksel_field == CLK_PLLA) ? CLK_PLLA :
      (dac_clksel_field == CLK_PLLB) ? CLK_PLLB : CLK_MCLK;

   // the rate reference follows whatever feeds dac1
   // receiver mode moves the reference back to the primary frame clock
   arcs_ref_t ref_d;
   assign ref_d = power_down_d ? ARCS_REF_SUBFRAME :
      (dac1_source_sel == SRC_SECONDARY) ? ARCS_REF_SECONDARY :
      ARCS_REF_PRIMARY;

   // dac clock source code
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         dac_clk_source_o <= CLK_MCLK;
      else
         dac_clk_source_o <= clk_src_d;
   end

   // dacs 2 and 3 power down level
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         dac23_power_down_o <= 1'b0;
      else
         dac23_power_down_o <= power_down_d;
   end

   // rate reference select, one-hot
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         dac_rate_ref_o <= ARCS_REF_PRIMARY;
      else
         dac_rate_ref_o <= ref_d;
   end

   // frame clock chosen by the registered reference; a switch costs up to two
   // bad periods, which the meter overwrites by the second new frame edge
   logic ref_frame;
   always_comb
   begin
      unique case (dac_rate_ref_o)
         ARCS_REF_PRIMARY: ref_frame = prim_frame_s;
         ARCS_REF_SECONDARY: ref_frame = sec_frame_s;
         ARCS_REF_SUBFRAME: ref_frame = subframe_s;
         default: ref_frame = prim_frame_s;
      endcase
   end

   // ratio meter on the chosen reference frame clock
   arcs_rate_meter #(
      .MCLK_PIN_HZ(MCLK_PIN_HZ),
      .PLL_A_HZ(PLL_A_HZ),
      .PLL_B_HZ(PLL_B_HZ)
   ) u_rate_meter (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .frame_clk_i(ref_frame),
      .clk_source_i(dac_clk_source_o),
      .rate_code_o(dac_rate_code_o)
   );

endmodule : arcs_routing

// [bench/arcs_routing_sva.sv]
// port assertions for the audio routing and clock select block
// assumes the host never writes one register on two cycles in a row
`timescale 1ns/100ps

module arcs_routing_chk (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic reg_wr_i,
   input wire logic [arcs_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic [arcs_pkg::REG_DW-1:0] reg_wdata_i,
   input wire logic [2:0] adc_clock_ratio_i,
   input wire logic [2:0] dac_data_o,
   input wire logic adc_highpass_bypass_o,
   input wire arcs_pkg::arcs_osr_t adc_osr_o,
   input wire logic adc_left_mute_o,
   input wire logic adc_right_mute_o,
   input wire logic [1:0] dac_clk_source_o,
   input wire logic dac23_power_down_o,
   input wire arcs_pkg::arcs_ref_t dac_rate_ref_o
);
   import arcs_pkg::*;
   logic adc_wr;

   // adc control writes land on the outputs two edges later
   assign adc_wr = reg_wr_i && reg_addr_i == REG_ADDR[IDX_ADCC1];

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_HPF_BYPASS: assert property (
      adc_wr |-> ##2 adc_highpass_bypass_o == $past(reg_wdata_i[4], 2))
      else $error("hpf bypass does not follow written bit");
   AST_MUTE_LEFT: assert property (
      adc_wr |-> ##2 adc_left_mute_o ==
         ($past(reg_wdata_i[0], 2) | $past(reg_wdata_i[2], 2)))
      else $error("left mute wrong");
   AST_MUTE_RIGHT: assert property (
      adc_wr |-> ##2 adc_right_mute_o ==
         ($past(reg_wdata_i[1], 2) | $past(reg_wdata_i[2], 2)))
      else $error("right mute wrong");
   AST_OSR_HALVED: assert property (
      adc_osr_o == ARCS_OSR_32 |-> $past(adc_clock_ratio_i) <= 3'h1)
      else $error("32fs without a low clock ratio");
   AST_OSR_FULL: assert property (
      $past(reset_n_i) && adc_osr_o == ARCS_OSR_128
         |-> $past(adc_clock_ratio_i) > 3'h1)
      else $error("128fs at a low clock ratio");
   AST_PWR_DOWN: assert property (
      dac23_power_down_o |-> dac_data_o[2:1] == 2'h0
         && dac_clk_source_o == CLK_PLLA)
      else $error("powered down dacs not quiet or not on pll a");
   AST_SUBFRAME_REF: assert property (
      (dac_rate_ref_o == ARCS_REF_SUBFRAME) == dac23_power_down_o)
      else $error("subframe reference and power down disagree");
   AST_CLK_CODE: assert property (
      dac_clk_source_o != 2'h3)
      else $error("dac clock source code 3 seen");
   AST_PWR_HOLD: assert property (
      dac23_power_down_o && !reg_wr_i && !$past(reg_wr_i)
         |=> dac23_power_down_o)
      else $error("power down dropped without a write");

   // main scenarios reached
   COV_PWR: cover property (dac23_power_down_o);
   COV_OSR32: cover property (adc_osr_o == ARCS_OSR_32);
   COV_SEC: cover property (dac_rate_ref_o == ARCS_REF_SECONDARY);
endmodule : arcs_routing_chk

bind arcs_routing arcs_routing_chk u_chk (
   .core_clk_i(core_clk_i),
   .reset_n_i(reset_n_i),
   .reg_wr_i(reg_wr_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .adc_clock_ratio_i(adc_clock_ratio_i),
   .dac_data_o(dac_data_o),
   .adc_highpass_bypass_o(adc_highpass_bypass_o),
   .adc_osr_o(adc_osr_o),
   .adc_left_mute_o(adc_left_mute_o),
   .adc_right_mute_o(adc_right_mute_o),
   .dac_clk_source_o(dac_clk_source_o),
   .dac23_power_down_o(dac23_power_down_o),
   .dac_rate_ref_o(dac_rate_ref_o)
);

// [bench/arcs_far_model.sv]
// far side model: serial sources and free running frame clocks
// assumes one core clock; outputs move just after a rising edge
`timescale 1ns/100ps

module arcs_far_model #(
   parameter int P_PRI = 1042,
   parameter int P_SEC = 2083,
   parameter int P_SUB = 695
) (
   input wire logic core_clk_i,
   output logic [2:0] pins_o,
   output logic [3:0] streams_o,
   output logic mux_o,
   output logic [2:0] frame_o
);
   localparam int PER [3] = '{P_PRI, P_SEC, P_SUB};
   int cnt [3] = '{0, 0, 0};

   // fresh random bits each cycle, so a stale path seldom matches by luck across repeated checks
   initial
   begin
      pins_o = 3'h0;
      streams_o = 4'h0;
      mux_o = 1'b0;
      frame_o = 3'h0;
   end
   always @(posedge core_clk_i)
   begin
      pins_o <= 3'($urandom);
      streams_o <= 4'($urandom);
      mux_o <= 1'($urandom);
   end

   // all frame clocks share one source, so subframe stays synchronous
   always @(posedge core_clk_i)
   begin
      for (int i = 0; i < 3; i++)
      begin
         cnt[i] <= (cnt[i] + 1) % PER[i];
         frame_o[i] <= cnt[i] < PER[i] / 2;
      end
   end
endmodule : arcs_far_model

// [bench/tb_top.sv]
// self-checking bench: shadow registers and input history predict outputs
// assumes arcs_far_model supplies the streams and frame clocks
`timescale 1ns/100ps

module tb_top;
   import arcs_pkg::*;
   localparam longint MCLK = 12_288_000;
   localparam int PER [3] = '{1042, 2083, 695};
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [REG_AW-1:0] reg_addr_i = '0;
   logic [REG_DW-1:0] reg_wdata_i = '0;
   logic [2:0] ratio = 3'h2;
   logic [2:0] pins, fr, dac_d, rcode;
   logic [3:0] st, st_h;
   logic [2:0] mux_h;
   logic mux, ptx, stx, sptx, opin, hpf, mute_l, mute_r, pwd;
   logic [REG_DW-1:0] rdata;
   logic [1:0] clk_src;
   arcs_osr_t osr;
   arcs_ref_t rref;
   logic [REG_DW-1:0] sh [REG_NUM];
   logic [2:0] pin_h [3];
   int miscompares = 0;
   int n_checks = 0;

   always #10 core_clk_i = ~core_clk_i;

   // what the block sampled at each edge, newest first
   always @(posedge core_clk_i)
   begin
      pin_h <= '{pins, pin_h[0], pin_h[1]};
      mux_h <= {mux_h[1:0], mux};
      st_h <= st;
   end

   arcs_far_model far (.core_clk_i(core_clk_i), .pins_o(pins),
      .streams_o(st), .mux_o(mux), .frame_o(fr));

   arcs_routing #(.MCLK_PIN_HZ(MCLK), .PLL_A_HZ(MCLK), .PLL_B_HZ(MCLK)) dut (
      .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
      .dac_serial_inputs_i(pins), .spdif_rx_data_i(st[0]),
      .secondary_rx_data_i(st[1]), .adc_data_i(st[2]),
      .spdif_tx_stream_i(st[3]), .spdif_in_mux_i(mux),
      .primary_rx_frame_clock_i(fr[0]), .secondary_frame_clock_i(fr[1]),
      .spdif_subframe_clock_i(fr[2]), .adc_clock_ratio_i(ratio),
      .dac_data_o(dac_d), .primary_tx_data_o(ptx),
      .secondary_tx_data_o(stx), .spdif_tx_data_o(sptx),
      .spdif_out_pin_o(opin), .adc_highpass_bypass_o(hpf),
      .adc_osr_o(osr), .adc_left_mute_o(mute_l),
      .adc_right_mute_o(mute_r), .dac_clk_source_o(clk_src),
      .dac23_power_down_o(pwd), .dac_rate_ref_o(rref),
      .dac_rate_code_o(rcode));

   task automatic check(input string what, input logic [8:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // one write, then an idle cycle so writes never run back to back
   task automatic wra(input logic [6:0] a, input logic [8:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : wra

   task automatic wr(input int idx, input logic [8:0] d);
      sh[idx] = d;
      wra(REG_ADDR[idx], d);
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [8:0] q);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      q = rdata;
      @(posedge core_clk_i);
   endtask : rd

   // expected {out pin, spdif tx, sec tx, pri tx, dac3..dac1}
   function automatic logic [6:0] exp_route();
      logic [2:0] d;
      logic [3:0] v;
      logic [1:0] c1, cp, cs, ct;
      logic pd;
      for (int k = 0; k < 3; k++)
         d[k] = sh[IDX_PCFG3][2*k+:2] == 2'h3 ? 1'b0 :
            pin_h[2][sh[IDX_PCFG3][2*k+:2]];
      v = {d[0], st_h[1], st_h[2], st_h[0]};
      c1 = sh[IDX_PCFG3][8:7];
      cp = sh[IDX_PCFG4][8:7];
      cs = sh[IDX_SCFG2][8:7];
      ct = sh[IDX_SPTX0][1:0];
      pd = c1 == 2'h0 && !sh[IDX_DACC1][8];
      return {sh[IDX_SPTX0][3] ? mux_h[2] : st_h[3], v[ct],
         v[cs] & (cs != 2'h2), v[cp] & (cp != 2'h3),
         pd ? 2'h0 : d[2:1], v[c1] & (c1 != 2'h1)};
   endfunction : exp_route

   function automatic logic [2:0] exp_code(input longint p);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < RATIO_NUM - 1; i++)
         if (p * 2 * MCLK > (RATIO_FS[i] + RATIO_FS[i+1]) * 50_000_000)
            n++;
      return n;
   endfunction : exp_code

   // main sequence
   initial
   begin
      logic [8:0] q, w;
      void'($urandom(32'hf0a1));
      repeat (12) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(posedge core_clk_i);
      for (int i = 0; i < REG_NUM; i++)
         rd(REG_ADDR[i], sh[i]);
      check("dac1 src", 9'(sh[IDX_PCFG3][8:7]), 9'h003);
      check("ptx src", 9'(sh[IDX_PCFG4][8:7]), 9'h001);
      check("stx src", 9'(sh[IDX_SCFG2][8:7]), 9'h000);
      check("tx src", 9'(sh[IDX_SPTX0][3:0]), 9'h000);
      check("dac clk", 9'(sh[IDX_CLK][1:0]), 9'h000);
      check("adc ctl", 9'(sh[IDX_ADCC1][4:0]), 9'h000);
      check("rx mode", 9'(sh[IDX_DACC1][8]), 9'h000);
      for (int i = 0; i < REG_NUM; i++)
      begin
         wr(i, 9'($urandom));
         rd(REG_ADDR[i], q);
         check("readback", q, sh[i]);
      end
      wra(7'h10, 9'h1FF);
      rd(7'h10, q);
      check("unmapped", q, 9'h000);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge core_clk_i);
         w = 9'($urandom);
         wr(IDX_PCFG3, {2'(i), w[6:0]});
         wr(IDX_PCFG4, {2'(i >> 2), w[6:0]});
         wr(IDX_SCFG2, {2'(i + 1), w[6:0]});
         wr(IDX_SPTX0, {w[8:4], i[0] ^ i[2], w[2], 2'(i + 2)});
         wr(IDX_DACC1, {i[3], w[7:0]});
         repeat (3) @(posedge core_clk_i);
         repeat (8)
         begin
            @(negedge core_clk_i);
            check("routing", 9'(exp_route()), {2'h0, opin, sptx, stx, ptx,
               dac_d});
         end
      end
      for (int j = 0; j < 32; j++)
      begin
         @(posedge core_clk_i);
         wr(IDX_PCFG3, {2'(j), sh[IDX_PCFG3][6:0]});
         wr(IDX_CLK, {sh[IDX_CLK][8:2], 2'(j >> 2)});
         wr(IDX_DACC1, {j[4], sh[IDX_DACC1][7:0]});
         repeat (2) @(negedge core_clk_i);
         check("clk src", 9'(clk_src),
            9'(j % 4 == 0 ? 1 : (j / 4) % 4 % 3));
         check("pwr down", 9'(pwd),
            9'(j % 4 == 0 && j < 16));
         check("rate ref", 9'(rref),
            9'(j % 4 == 0 && j < 16 ? 4 : j % 4 == 2 ? 2 : 1));
      end
      for (int i = 0; i < 14; i++)
      begin
         @(posedge core_clk_i);
         w = 9'($urandom);
         w[3] = i[0];
         ratio <= 3'(i >> 1);
         wr(IDX_ADCC1, w);
         repeat (2) @(negedge core_clk_i);
         check("adc ctl", 9'({hpf, mute_l, mute_r}),
            9'({w[4], w[0] | w[2], w[1] | w[2]}));
         check("adc osr", 9'(osr),
            9'(i < 4 ? (i[0] ? 4 : 2) : (i[0] ? 2 : 1)));
      end
      @(posedge core_clk_i);
      wr(IDX_DACC1, 9'h000);
      for (int r = 0; r < 3; r++)
      begin
         wr(IDX_PCFG3, {r == 0 ? 2'h3 : r == 1 ? 2'h2 : 2'h0,
            sh[IDX_PCFG3][6:0]});
         repeat (3 * PER[r] + 20) @(negedge core_clk_i);
         check("rate code", 9'(rcode), 9'(exp_code(PER[r])));
         @(posedge core_clk_i);
      end
      end_of_test();
   end

   // watchdog well past the expected run length
   initial
   begin
      repeat (40000) @(posedge core_clk_i);
      miscompares++;
      end_of_test();
   end
endmodule : tb_top
